// >>> logic/ext_bus_pkg.sv
// shared constants and carrier types for the external memory bus interface
// assumes a single 50 MHz core clock; no software register bus
package ext_bus_pkg;
	// ==========================================
	// machine timing
	localparam int CLKS_PER_MC = 4;
	localparam int RESET_HOLD_MC = 2;
	localparam int RESET_HOLD_CLKS = RESET_HOLD_MC * CLKS_PER_MC;
	localparam logic [3:0] STRETCH_MIN = 4'h2;
	localparam logic [3:0] STRETCH_MAX = 4'h9;
	// ==========================================
	// memory map
	localparam logic [15:0] SRAM_LAST = 16'h03ff;
	localparam int SRAM_DEPTH = 1024;
	localparam int SRAM_AW = 10;
	localparam logic [7:0] OP_DEC_PTR = 8'ha5;
	localparam logic [7:0] PORT_IDLE = 8'hff;

	typedef enum logic [1:0] {REQ_FETCH, REQ_CODE_READ, REQ_DATA_READ, REQ_DATA_WRITE} req_kind_t;

	// request from the core sequencer
	typedef struct packed {
		logic valid;
		req_kind_t kind;
		logic use_ptr;
		logic [15:0] addr;
		logic [7:0] wdata;
	} bus_req_t;

	// pin-side strobes, active low except ale, which is active high
	typedef struct packed {
		logic ale;
		logic program_store_strobe_n;
		logic rd_n;
		logic wr_n;
	} bus_strobe_t;

	typedef enum {ST_IDLE, ST_ADDR, ST_STROBE, ST_STRETCH, ST_DONE, ST_SRAM} bus_state_t;
endpackage : ext_bus_pkg

// >>> logic/onchip_sram.sv
// single-port data SRAM with registered read data
// assumes one synchronous clock; contents undefined after power-up
`timescale 1ns/1ns
module onchip_sram #(
	parameter int AW = 10,
	parameter int DEPTH = 1024
) (
	input wire logic core_clk,
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem [DEPTH];

	// ==========================================
	// storage
	// write and registered read share one port
	always_ff @(posedge core_clk)
	begin
		if (we)
			mem[addr] <= wdata;
		rdata <= mem[addr];
	end
endmodule : onchip_sram

// >>> logic/ext_memory_bus_interface.sv
// external memory bus sequencer: muxed address/data, upper address, strobes,
// stretched data cycles, wait input, dual data pointers, on-chip data SRAM window
// assumes the core hands over one request at a time and waits for done
`timescale 1ns/1ns
module ext_memory_bus_interface (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic reset_pin,
	input wire logic external_access_enable_in,
	input wire ext_bus_pkg::bus_req_t req,
	input wire logic [7:0] opcode,
	input wire logic opcode_valid,
	input wire logic ptr_select,
	input wire logic ptr_load,
	input wire logic [15:0] ptr_load_value,
	input wire logic onchip_sram_enable_bit,
	input wire logic [3:0] stretch_mc,
	input wire logic wait_enable,
	input wire logic wait_pin_n,
	input wire logic [7:0] port0_in,
	output logic [7:0] port0_out,
	output logic port0_oe_n,
	output logic [7:0] port2_out,
	output ext_bus_pkg::bus_strobe_t strobes,
	output logic [7:0] rdata,
	output logic done,
	output logic core_reset,
	output logic [15:0] data_pointer0,
	output logic [15:0] data_pointer1,
	output logic sram_active
);
	import ext_bus_pkg::*;

	typedef struct packed {
		logic [1:0] rst_sync;
		logic [1:0] wait_sync;
		logic [1:0] ea_sync;
		logic [3:0] rst_cnt;
		logic core_reset;
		logic [1:0] phase;
		logic mc_tick;
		bus_state_t st;
		bus_req_t cur;
		logic [3:0] mc_left;
		logic dme;
		logic [15:0] dp0;
		logic [15:0] dp1;
		logic [7:0] p0;
		logic p0_oe_n;
		logic [7:0] p2;
		bus_strobe_t stb;
		logic [7:0] rdata;
		logic done;
		logic sram_rd;
	} state_t;

	state_t s_q;
	state_t s_d;
	logic sram_we;
	logic [7:0] sram_rdata;

	// clamp the programmed stretch into the legal window
	function automatic logic [3:0] clamp_mc(input logic [3:0] v);
		if (v < STRETCH_MIN)
			return STRETCH_MIN;
		else if (v > STRETCH_MAX)
			return STRETCH_MAX;
		else
			return v;
	endfunction : clamp_mc

	// true when a data move falls in the enabled on-chip window
	function automatic logic in_sram(input logic en, input logic [15:0] a);
		return en && (a <= SRAM_LAST);
	endfunction : in_sram

	onchip_sram #(
		.AW(SRAM_AW),
		.DEPTH(SRAM_DEPTH)
	) u_sram (
		.core_clk(core_clk),
		.we(sram_we),
		.addr(s_d.cur.addr[SRAM_AW-1:0]),
		.wdata(s_d.cur.wdata),
		.rdata(sram_rdata)
	);

	// sram write fires in the cycle the request is accepted; held reset refuses requests
	assign sram_we = !s_q.core_reset && (s_q.st == ST_IDLE) && req.valid && (req.kind == REQ_DATA_WRITE)
		&& in_sram(s_q.dme, req.use_ptr ? (ptr_select ? s_q.dp1 : s_q.dp0) : req.addr);

	// ==========================================
	// next-state logic
	always_comb
	begin
		logic [15:0] a;
		logic data_cycle;
		a = 16'h0000;
		data_cycle = 1'b0;
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.sram_rd = 1'b0;
		// reset, wait and access-enable pins pass two flops first
		s_d.rst_sync = {s_q.rst_sync[0], reset_pin};
		s_d.wait_sync = {s_q.wait_sync[0], wait_pin_n};
		s_d.ea_sync = {s_q.ea_sync[0], external_access_enable_in}; // observed only
		// reset needs a held-high pin for two machine cycles
		if (!s_q.rst_sync[1])
		begin
			s_d.rst_cnt = 4'h0;
			s_d.core_reset = 1'b0;
		end
		else if (s_q.rst_cnt == 4'(RESET_HOLD_CLKS - 1))
			s_d.core_reset = 1'b1;
		else
			s_d.rst_cnt = s_q.rst_cnt + 4'h1;
		// machine cycle divider, one tick every four clocks
		s_d.phase = s_q.phase + 2'h1;
		s_d.mc_tick = (s_q.phase == 2'(CLKS_PER_MC - 2));
		// sram enable latched from the core, cleared by reset
		s_d.dme = onchip_sram_enable_bit;
		// data pointers: load, or decrement on A5H
		if (ptr_load)
		begin
			if (ptr_select)
				s_d.dp1 = ptr_load_value;
			else
				s_d.dp0 = ptr_load_value;
		end
		else if (opcode_valid && opcode == OP_DEC_PTR)
		begin
			if (ptr_select)
				s_d.dp1 = s_q.dp1 - 16'h0001;
			else
				s_d.dp0 = s_q.dp0 - 16'h0001;
		end
		if (s_q.core_reset)
		begin
			s_d.st = ST_IDLE;
			s_d.dme = 1'b0;
			s_d.stb = '{ale: 1'b0, program_store_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
			s_d.p0_oe_n = 1'b1;
			s_d.dp0 = 16'h0000;
			s_d.dp1 = 16'h0000;
		end
		else
		begin
			data_cycle = (s_q.cur.kind == REQ_DATA_READ) || (s_q.cur.kind == REQ_DATA_WRITE);
			case (s_q.st)
				ST_IDLE:
				begin
					if (req.valid)
					begin
						s_d.cur = req;
						a = req.use_ptr ? (ptr_select ? s_q.dp1 : s_q.dp0) : req.addr;
						s_d.cur.addr = a;
						s_d.mc_left = clamp_mc(stretch_mc);
						if ((req.kind == REQ_DATA_READ || req.kind == REQ_DATA_WRITE) && in_sram(s_q.dme, a))
						begin
							s_d.st = ST_SRAM;
							s_d.sram_rd = 1'b1;
						end
						else
							s_d.st = ST_ADDR;
					end
				end
				ST_ADDR:
				begin
					// address out with latch strobe high, no read/write yet
					s_d.p0 = s_q.cur.addr[7:0];
					s_d.p0_oe_n = 1'b0;
					s_d.p2 = s_q.cur.addr[15:8];
					s_d.stb.ale = 1'b1;
					if (s_q.mc_tick)
						s_d.st = ST_STROBE;
				end
				ST_STROBE:
				begin
					// latch closed, then data phase on the shared port
					s_d.stb.ale = 1'b0;
					if (s_q.cur.kind == REQ_DATA_WRITE)
					begin
						s_d.p0 = s_q.cur.wdata;
						s_d.stb.wr_n = 1'b0;
					end
					else
					begin
						s_d.p0_oe_n = 1'b1; // port released for incoming data
						if (data_cycle)
							s_d.stb.rd_n = 1'b0;
						else
							s_d.stb.program_store_strobe_n = 1'b0;
					end
					if (s_q.mc_tick)
					begin
						s_d.mc_left = s_q.mc_left - 4'h1;
						s_d.st = ST_STRETCH;
					end
				end
				ST_STRETCH:
				begin
					// fetches end at the first tick here, two machine cycles of strobe; data cycles honour stretch and wait
					if (s_q.mc_tick)
					begin
						if (!data_cycle || (s_q.mc_left <= 4'h1 && !(wait_enable && !s_q.wait_sync[1])))
						begin
							s_d.rdata = port0_in;
							s_d.st = ST_DONE;
						end
						else if (s_q.mc_left > 4'h1)
							s_d.mc_left = s_q.mc_left - 4'h1;
					end
				end
				ST_DONE:
				begin
					s_d.stb = '{ale: 1'b0, program_store_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
					s_d.p0_oe_n = 1'b1;
					s_d.p0 = PORT_IDLE;
					s_d.done = 1'b1;
					s_d.st = ST_IDLE;
				end
				ST_SRAM:
				begin
					s_d.rdata = sram_rdata;
					s_d.done = 1'b1;
					s_d.st = ST_IDLE;
				end
				default:
					s_d.st = ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.mc_left <= STRETCH_MIN;
			s_q.p0 <= PORT_IDLE;
			s_q.p0_oe_n <= 1'b1;
			s_q.stb <= '{ale: 1'b0, program_store_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
		end
		else
			s_q <= s_d;
	end

	// outputs straight from the state flops
	assign port0_out = s_q.p0;
	assign port0_oe_n = s_q.p0_oe_n;
	assign port2_out = s_q.p2;
	assign strobes = s_q.stb;
	assign rdata = s_q.rdata;
	assign done = s_q.done;
	assign core_reset = s_q.core_reset;
	assign data_pointer0 = s_q.dp0;
	assign data_pointer1 = s_q.dp1;
	assign sram_active = s_q.dme;
endmodule : ext_memory_bus_interface

// >>> tb/ext_bus_assertions.sv
// pin-order checks for the bus sequencer
// assumes it is bound onto the sequencer top
`timescale 1ns/1ns
module ext_bus_assertions (
	input wire logic core_clk,
	input wire logic nrst,
	input wire ext_bus_pkg::bus_strobe_t strobes,
	input wire logic port0_oe_n,
	input wire logic [7:0] port2_out,
	input wire logic done,
	input wire logic sram_active
);
	import ext_bus_pkg::*;
	// ==========
	// strobe order, one clock domain
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	sequence s_rd_end;
		!strobes.rd_n ##1 strobes.rd_n;
	endsequence
	a_ale_before_rd:
		assert property ($fell(strobes.rd_n) |-> $past(strobes.ale)) else $error("read before latch");
	a_ale_before_wr:
		assert property ($fell(strobes.wr_n) |-> $past(strobes.ale)) else $error("write before latch");
	a_ale_before_ps:
		assert property ($fell(strobes.program_store_strobe_n) |-> $past(strobes.ale)) else $error("fetch before latch");
	a_rd_end_done:
		assert property (s_rd_end |-> done) else $error("read ended without done");
	a_wr_drives_bus:
		assert property (!strobes.wr_n |-> !port0_oe_n) else $error("write data not driven");
	a_rd_frees_bus:
		assert property (!(strobes.rd_n && strobes.program_store_strobe_n) |-> port0_oe_n) else $error("bus held on read");
	a_upper_addr_held:
		assert property (!strobes.rd_n && !$past(strobes.rd_n) |-> $stable(port2_out)) else $error("upper address moved");
	a_sram_quiet:
		assert property (sram_active && !(strobes.rd_n && strobes.wr_n) |-> port2_out > SRAM_LAST[15:8])
		else $error("data strobe inside enabled sram window");
endmodule : ext_bus_assertions

bind ext_memory_bus_interface ext_bus_assertions u_chk (.core_clk, .nrst, .strobes, .port0_oe_n, .port2_out, .done,
	.sram_active);

// >>> tb/ext_mem_model.sv
// far-side ROM, RAM and slow device behind an address latch
// assumes strobes from the sequencer, one clock
`timescale 1ns/1ns
module ext_mem_model (
	input wire logic core_clk,
	input wire ext_bus_pkg::bus_strobe_t strobes,
	input wire logic [7:0] port0_out,
	input wire logic [7:0] port2_out,
	input wire logic slow,
	output logic [7:0] port0_in,
	output logic wait_pin_n
);
	logic [7:0] mem [65536];
	logic [7:0] lo_q = 8'h00;
	logic [7:0] last_q = 8'h00;
	int n_q = 0;
	wire logic rd = !strobes.rd_n || !strobes.program_store_strobe_n;
	wire logic [15:0] adr = {port2_out, lo_q};
	// unwritten bytes read as a fold of their address
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'(i) ^ 8'(i >> 8);
	end
	// latch open while ale high; write data taken each strobe clock
	always @(posedge core_clk)
	begin
		if (strobes.ale)
			lo_q <= port0_out;
		if (!strobes.wr_n)
			mem[adr] <= port0_out;
		n_q <= (rd || !strobes.wr_n) ? n_q + 1 : 0;
		last_q <= port0_in;
	end
	// released bus shows a toggling pattern, never a stale byte
	assign port0_in = rd ? mem[adr] : ~last_q;
	// slow device stalls the first ten strobe clocks
	assign wait_pin_n = !(slow && (rd || !strobes.wr_n) && n_q < 10);
endmodule : ext_mem_model

// >>> tb/testbench.sv
// self-checking bench: sequencer, far-side memory, expected-memory model
// assumes design, checker and memory model compiled first
`timescale 1ns/1ns
module testbench;
	import ext_bus_pkg::*;
	logic core_clk = 0, nrst = 0, reset_pin = 0, opcode_valid = 0, ptr_select = 0, ptr_load = 0;
	logic onchip_sram_enable_bit = 0, wait_enable = 0, slow = 0;
	logic [7:0] opcode = 8'h00, d, port0_in, port0_out, port2_out, rdata;
	logic [15:0] ptr_load_value = 16'h0000, a, e, data_pointer0, data_pointer1;
	logic [3:0] stretch_mc = 4'h2;
	logic wait_pin_n, port0_oe_n, done, core_reset, sram_active;
	bus_req_t req = '0;
	bus_strobe_t strobes;
	logic [7:0] ext [logic [15:0]];
	int n_rd, n_wr, n_ps, n_al, prev, failures = 0, n_compared = 0;
	always #10 core_clk = ~core_clk;
	ext_memory_bus_interface dut (.core_clk, .nrst, .reset_pin, .external_access_enable_in(1'b0), .req, .opcode,
		.opcode_valid, .ptr_select, .ptr_load, .ptr_load_value, .onchip_sram_enable_bit, .stretch_mc, .wait_enable,
		.wait_pin_n, .port0_in, .port0_out, .port0_oe_n, .port2_out, .strobes, .rdata, .done, .core_reset,
		.data_pointer0, .data_pointer1, .sram_active);
	ext_mem_model far (.core_clk, .strobes, .port0_out, .port2_out, .slow, .port0_in, .wait_pin_n);
	// strobe clocks counted per transfer
	always @(posedge core_clk)
	begin
		n_rd += !strobes.rd_n;
		n_wr += !strobes.wr_n;
		n_ps += !strobes.program_store_strobe_n;
		n_al += strobes.ale;
	end
	function automatic logic [7:0] ex(input logic [15:0] x);
		return ext.exists(x) ? ext[x] : x[7:0] ^ x[15:8];
	endfunction : ex
	task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
		n_compared++;
		if (g !== x)
		begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, x, g);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	// request held until done, then one idle edge before the next
	task automatic xfer(input req_kind_t k, input logic [15:0] x, input logic [7:0] w, input logic up);
		int i;
		{n_rd, n_wr, n_ps, n_al} = '0;
		req = '{1'b1, k, up, x, w};
		for (i = 0; i < 300 && done !== 1'b1; i++)
			cyc(1);
		if (i == 300)
		begin
			failures++;
			tally_and_finish();
		end
		req.valid = 1'b0;
		cyc(1);
	endtask : xfer
	// ==========
	// main sequence
	initial
	begin
		void'($urandom(19303));
		cyc(8);
		nrst = 1;
		cyc(2);
		for (int j = 0; j < 6; j++)
		begin
			a = (j < 3) ? 16'($urandom % 1024) : 16'($urandom);
			d = 8'($urandom);
			ext[a] = d;
			xfer(REQ_DATA_WRITE, a, d, 0);
			chk("write strobe", 1, n_wr > 0);
			chk("latch strobe", 1, n_al > 0);
			xfer(REQ_DATA_READ, a, 8'h00, 0);
			chk("read data", ex(a), rdata);
		end
		onchip_sram_enable_bit = 1;
		for (int k = 0; k < 2; k++)
		begin
			xfer(req_kind_t'(k), 16'h0100, 8'h00, 0);
			chk("program strobe", 1, n_ps > 0);
			chk("code byte", ex(16'h0100), rdata);
		end
		// window edges: 03ff on chip, 0400 outside
		xfer(REQ_DATA_WRITE, 16'h03ff, 8'h5a, 0);
		chk("sram write quiet", 0, 16'(n_al + n_wr));
		xfer(REQ_DATA_READ, 16'h03ff, 8'h00, 0);
		chk("sram read", 16'h005a, rdata);
		xfer(REQ_DATA_READ, 16'h0400, 8'h00, 0);
		chk("above window", ex(16'h0400), rdata);
		for (int s = 2; s <= 9; s++)
		begin
			stretch_mc = 4'(s);
			xfer(REQ_DATA_READ, 16'h1234, 8'h00, 0);
			if (s > 2)
				chk("stretch step", 16'(CLKS_PER_MC), 16'(n_rd - prev));
			chk("stretch length", 16'(s * CLKS_PER_MC), 16'(n_rd));
			prev = n_rd;
		end
		// out-of-range settings fall back to the nearest legal length
		stretch_mc = 4'h0;
		xfer(REQ_DATA_READ, 16'h1234, 8'h00, 0);
		chk("stretch clamp low", 16'(int'(STRETCH_MIN) * CLKS_PER_MC), 16'(n_rd));
		stretch_mc = 4'hf;
		xfer(REQ_DATA_READ, 16'h1234, 8'h00, 0);
		chk("stretch clamp high", 16'(int'(STRETCH_MAX) * CLKS_PER_MC), 16'(n_rd));
		// slow device on the shortest cycle must lengthen it
		stretch_mc = 4'h2;
		wait_enable = 1;
		slow = 1;
		xfer(REQ_DATA_READ, 16'h1234, 8'h00, 0);
		chk("wait longer", 1, n_rd > prev - 7 * CLKS_PER_MC);
		chk("wait data", ex(16'h1234), rdata);
		slow = 0;
		e = 16'($urandom);
		ptr_load_value = e;
		ptr_load = 1;
		cyc(1);
		ptr_select = 1;
		ptr_load_value = 16'h0000;
		cyc(1);
		ptr_load = 0;
		opcode = OP_DEC_PTR;
		opcode_valid = 1;
		cyc(1);
		opcode_valid = 0;
		cyc(2);
		chk("pointer0", e, data_pointer0);
		chk("pointer1", 16'hffff, data_pointer1);
		xfer(REQ_DATA_READ, 16'h1357, 8'h00, 1);
		chk("pointer read", ex(16'hffff), rdata);
		// short pin pulse ignored, held pin resets
		reset_pin = 1;
		cyc(3);
		reset_pin = 0;
		cyc(20);
		chk("short pulse", 0, core_reset);
		reset_pin = 1;
		cyc(RESET_HOLD_CLKS + 8);
		chk("held pin", 1, core_reset);
		chk("pointer cleared", 0, data_pointer1);
		reset_pin = 0;
		cyc(20);
		tally_and_finish();
	end
endmodule : testbench
